// file: rtl/opt_pipe.sv
// operand execution pipe: instruction cost sequencing and operand accesses
`timescale 1ns/1ps
`include "opt_defines.svh"
module opt_pipe #(
    parameter int ADDR_W = `OPT_ADDR_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ins_valid,
    output logic ins_ready,
    input wire opt_pkg::opt_op_e ins_op,
    input wire opt_pkg::opt_size_e ins_size,
    input wire opt_pkg::opt_mode_e ins_src_mode,
    input wire opt_pkg::opt_mode_e ins_dst_mode,
    input wire logic [ADDR_W-1:0] ins_src_addr,
    input wire logic [ADDR_W-1:0] ins_dst_addr,
    input wire logic [7:0] ins_base_cycles,
    output logic store_stall,
    output logic ins_done,
    output logic ins_illegal,
    output logic mem_req,
    output logic mem_we,
    output opt_pkg::opt_size_e mem_size,
    output logic [ADDR_W-1:0] mem_addr
);
    import opt_pkg::*;

    function automatic logic [1:0] npieces(opt_size_e s, logic [1:0] a);
        logic [1:0] n;
        n = 2'h1;
        if (s == SZ_WORD && a[0])
            n = 2'h2;
        else if (s == SZ_LONG && a == 2'h2)
            n = 2'h2;
        else if (s == SZ_LONG && a[0])
            n = 2'h3;
        return n;
    endfunction

    // size of piece i of an operand: byte/word/byte for an odd long
    function automatic opt_size_e piece_size(opt_size_e s, logic [1:0] a, logic [1:0] i);
        opt_size_e r;
        r = s;
        if (s == SZ_WORD && a[0])
            r = SZ_BYTE;
        else if (s == SZ_LONG && a == 2'h2)
            r = SZ_WORD;
        else if (s == SZ_LONG && a[0])
            r = (i == 2'h1) ? SZ_WORD : SZ_BYTE;
        return r;
    endfunction

    function automatic logic [1:0] piece_off(opt_size_e s, logic [1:0] a, logic [1:0] i);
        logic [1:0] o;
        o = 2'h0;
        if (s == SZ_WORD && a[0])
            o = i;
        else if (s == SZ_LONG && a == 2'h2)
            o = {i[0], 1'b0};
        else if (s == SZ_LONG && a[0])
            o = (i == 2'h2) ? 2'h3 : i;
        return o;
    endfunction

    opt_state_e state, next_state;
    opt_op_e l_op, next_l_op;
    opt_size_e l_size, next_l_size;
    logic [ADDR_W-1:0] l_src, next_l_src, l_dst, next_l_dst;
    logic rd_left, next_rd_left;
    logic [7:0] wr_left, next_wr_left, cnt, next_cnt;
    logic [1:0] pidx, next_pidx, busy, next_busy;
    logic next_done, next_illegal, next_mem_req, next_mem_we;
    opt_size_e next_mem_size;
    logic [ADDR_W-1:0] next_mem_addr;
    logic [7:0] c_cycles, c_reads, c_writes, total;
    logic c_illegal, free, exec_last, in_store, acc_go;
    logic [1:0] np_src, np_dst, np_cur;

    opt_cost u_cost (
        .op(ins_op),
        .size(ins_size),
        .src_mode(ins_src_mode),
        .dst_mode(ins_dst_mode),
        .base_cycles(ins_base_cycles),
        .cycles(c_cycles),
        .reads(c_reads),
        .writes(c_writes),
        .illegal(c_illegal)
    );

    always_comb
    begin
        np_src = npieces(ins_size, ins_src_addr[1:0]);
        np_dst = npieces(ins_size, ins_dst_addr[1:0]);
        // a misaligned read adds one cycle per read piece, a misaligned write one per extra write piece
        total = c_cycles;
        if (ins_op != OP_MULTI && c_reads != 8'h00 && np_src != 2'h1)
            total = total + {6'h00, np_src};
        if (ins_op != OP_MULTI && c_writes != 8'h00)
            total = total + {6'h00, np_dst - 2'h1};
    end

    assign exec_last = (state == ST_EXEC) && (cnt == 8'h01);
    assign free = (state == ST_IDLE) || exec_last;
    // the transfer of many registers uses its own resources, so busy is ignored
    assign in_store = (c_writes != 8'h00) && (ins_op != OP_MULTI);
    assign store_stall = free && ins_valid && in_store && (busy != 2'h0);
    assign ins_ready = free && !store_stall;
    assign acc_go = ins_valid && ins_ready && !c_illegal;

    always_comb
    begin
        next_state = state;
        next_l_op = l_op;
        next_l_size = l_size;
        next_l_src = l_src;
        next_l_dst = l_dst;
        next_rd_left = rd_left;
        next_wr_left = wr_left;
        next_pidx = pidx;
        next_cnt = cnt;
        next_busy = (busy != 2'h0) ? busy - 2'h1 : 2'h0;
        next_done = 1'b0;
        next_illegal = ins_valid && ins_ready && c_illegal;
        next_mem_req = 1'b0;
        next_mem_we = 1'b0;
        next_mem_size = l_size;
        next_mem_addr = '0;
        np_cur = npieces(l_size, rd_left ? l_src[1:0] : l_dst[1:0]);
        if (state == ST_EXEC)
        begin
            // reads always go out before writes, one aligned piece per clock
            if (rd_left)
            begin
                next_mem_req = 1'b1;
                next_mem_size = piece_size(l_size, l_src[1:0], pidx);
                next_mem_addr = l_src + ADDR_W'(piece_off(l_size, l_src[1:0], pidx));
                next_pidx = (pidx == np_cur - 2'h1) ? 2'h0 : pidx + 2'h1;
                next_rd_left = (pidx != np_cur - 2'h1);
            end
            else if (wr_left != 8'h00)
            begin
                next_mem_req = 1'b1;
                next_mem_we = 1'b1;
                if (l_op == OP_MULTI)
                begin
                    next_mem_size = SZ_LONG;
                    next_mem_addr = l_dst;
                    next_l_dst = l_dst + ADDR_W'(`OPT_LONG_STEP);
                    next_wr_left = wr_left - 8'h01;
                end
                else
                begin
                    next_mem_size = piece_size(l_size, l_dst[1:0], pidx);
                    next_mem_addr = l_dst + ADDR_W'(piece_off(l_size, l_dst[1:0], pidx));
                    next_pidx = (pidx == np_cur - 2'h1) ? 2'h0 : pidx + 2'h1;
                    next_wr_left = (pidx == np_cur - 2'h1) ? 8'h00 : wr_left;
                end
            end
            next_cnt = cnt - 8'h01;
            if (exec_last)
            begin
                next_done = 1'b1;
                next_state = ST_IDLE;
            end
        end
        if (acc_go)
        begin
            next_state = ST_EXEC;
            next_l_op = ins_op;
            next_l_size = ins_size;
            next_l_src = ins_src_addr;
            next_l_dst = ins_dst_addr;
            next_rd_left = (c_reads != 8'h00);
            next_wr_left = c_writes;
            next_pidx = 2'h0;
            next_cnt = total;
            if (in_store)
                next_busy = `OPT_STORE_BUSY_CYC;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= ST_IDLE;
            l_op <= OP_MOVE;
            l_size <= SZ_BYTE;
            l_src <= '0;
            l_dst <= '0;
            rd_left <= 1'b0;
            wr_left <= 8'h00;
            pidx <= 2'h0;
            cnt <= 8'h00;
            busy <= 2'h0;
            ins_done <= 1'b0;
            ins_illegal <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_size <= SZ_BYTE;
            mem_addr <= '0;
        end
        else
        begin
            state <= next_state;
            l_op <= next_l_op;
            l_size <= next_l_size;
            l_src <= next_l_src;
            l_dst <= next_l_dst;
            rd_left <= next_rd_left;
            wr_left <= next_wr_left;
            pidx <= next_pidx;
            cnt <= next_cnt;
            busy <= next_busy;
            ins_done <= next_done;
            ins_illegal <= next_illegal;
            mem_req <= next_mem_req;
            mem_we <= next_mem_we;
            mem_size <= next_mem_size;
            mem_addr <= next_mem_addr;
        end
    end

    // checking helpers: cycles spent and cycles promised for the current instruction
    logic [7:0] run, l_total;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            run <= 8'h00;
            l_total <= 8'h00;
        end
        else
        begin
            run <= acc_go ? 8'h00 : run + 8'h01;
            l_total <= acc_go ? total : l_total;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_CYCLES: assert property (exec_last |-> run == l_total - 8'h01)
        else $error("instruction did not take its fixed cycle count");
    // judged on the current counters: a back-to-back take reloads the next_ values here
    AST_ALL_REFS: assert property (exec_last |-> (rd_left
        ? (wr_left == 8'h00 && pidx == np_cur - 2'h1)
        : (wr_left == 8'h00 || (l_op == OP_MULTI ? wr_left == 8'h01
        : pidx == np_cur - 2'h1))))
        else $error("operand references left over at instruction end");
    AST_RMW_ORDER: assert property (next_mem_we |-> !rd_left)
        else $error("write issued before the read completed");
    AST_STORE_GAP: assert property (acc_go && in_store |=> !(acc_go && in_store) [*2])
        else $error("store accepted inside the busy window");
    AST_STALL_MAX: assert property (store_stall ##1 store_stall |=> !store_stall)
        else $error("store stall longer than two cycles");
    AST_MULTI_EXEMPT: assert property (free && ins_valid && ins_op == OP_MULTI |-> ins_ready)
        else $error("multi-register transfer was stalled");
    AST_WORD_ALIGN: assert property (mem_req && mem_size == SZ_WORD |-> !mem_addr[0])
        else $error("word access not aligned");
    AST_LONG_ALIGN: assert property (mem_req && mem_size == SZ_LONG |-> mem_addr[1:0] == 2'h0)
        else $error("long access not aligned");
    AST_ODD_LONG: assert property (acc_go && ins_op == OP_RMW && ins_size == SZ_LONG
        && ins_src_addr[0] && ins_dst_addr[0] |-> total == c_cycles + 8'h05)
        else $error("odd long read-modify-write cost wrong");
    AST_PC_REL: assert property (acc_go && ins_op == OP_MOVE && ins_src_mode == M_PC_D16
        && ins_dst_mode == M_D16 |-> c_cycles == (ins_size == SZ_LONG ? 8'h02 : 8'h03))
        else $error("pc-relative move cost differs");
    AST_MOVE_BW: assert property (acc_go && ins_op == OP_MOVE && ins_size != SZ_LONG
        && ins_src_mode == M_DREG && ins_dst_mode == M_DREG |-> c_cycles == 8'h01)
        else $error("register move cost wrong");
    AST_MOVE_L: assert property (acc_go && ins_op == OP_MOVE && ins_size == SZ_LONG
        && ins_src_mode == M_IND && ins_dst_mode == M_IDX |-> c_cycles == 8'h03)
        else $error("long memory move cost wrong");
    AST_ILLEGAL: assert property (ins_valid && ins_op == OP_MOVE && ins_src_mode == M_IDX
        && ins_dst_mode == M_D16 |-> c_illegal)
        else $error("undefined move combination accepted");

    COV_STALL: cover property (store_stall ##1 store_stall);
    COV_MULTI: cover property (acc_go && ins_op == OP_MULTI);
    COV_BWB: cover property (mem_req && mem_size == SZ_BYTE ##1 mem_req && mem_size == SZ_WORD
        ##1 mem_req && mem_size == SZ_BYTE);
    COV_ILLEGAL: cover property (ins_illegal);
endmodule

// file: rtl/opt_defines.svh
// timing constants and field widths of the operand pipeline timing block
`ifndef OPT_DEFINES_SVH
`define OPT_DEFINES_SVH

`define OPT_CYC_W 8
`define OPT_ADDR_W 32
`define OPT_STORE_BUSY_CYC 2'h2
`define OPT_C_REG_MOVE 8'h01
`define OPT_C_MEM_BW 8'h03
`define OPT_C_MEM_L 8'h02
`define OPT_C_IMM_BW 8'h03
`define OPT_C_IMM_L 8'h02
`define OPT_C_IDX_ADD 8'h01
`define OPT_LONG_STEP 32'h0000_0004

`endif

// file: rtl/opt_pkg.sv
// types shared by the operand pipeline timing block
package opt_pkg;
    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} opt_size_e;
    typedef enum logic [3:0] {
        M_DREG, M_AREG, M_IND, M_POSTINC, M_PREDEC, M_D16, M_IDX,
        M_ABSW, M_ABSL, M_PC_D16, M_PC_IDX, M_IMM
    } opt_mode_e;
    typedef enum logic [1:0] {OP_MOVE, OP_RMW, OP_MULTI} opt_op_e;
    typedef enum logic {ST_IDLE, ST_EXEC} opt_state_e;
endpackage

// file: rtl/opt_cost.sv
// base cost lookup: cycles and operand references of one instruction
`timescale 1ns/1ps
`include "opt_defines.svh"
module opt_cost (
    input wire opt_pkg::opt_op_e op,
    input wire opt_pkg::opt_size_e size,
    input wire opt_pkg::opt_mode_e src_mode,
    input wire opt_pkg::opt_mode_e dst_mode,
    input wire logic [7:0] base_cycles,
    output logic [7:0] cycles,
    output logic [7:0] reads,
    output logic [7:0] writes,
    output logic illegal
);
    import opt_pkg::*;
    opt_mode_e src_m;
    logic src_reg, src_imm, src_idx, src_abs, src_mem, dst_reg, dst_idx, dst_abs, is_long;

    always_comb
    begin
        // pc-relative sources cost the same as their address-register forms
        src_m = src_mode;
        if (src_mode == M_PC_D16)
            src_m = M_D16;
        else if (src_mode == M_PC_IDX)
            src_m = M_IDX;
        src_reg = (src_m == M_DREG) || (src_m == M_AREG);
        src_imm = (src_m == M_IMM);
        src_idx = (src_m == M_IDX);
        src_abs = (src_m == M_ABSW) || (src_m == M_ABSL);
        src_mem = !src_reg && !src_imm;
        dst_reg = (dst_mode == M_DREG) || (dst_mode == M_AREG);
        dst_idx = (dst_mode == M_IDX);
        dst_abs = (dst_mode == M_ABSW) || (dst_mode == M_ABSL);
        is_long = (size == SZ_LONG);
        cycles = base_cycles;
        reads = 8'h00;
        writes = 8'h00;
        illegal = 1'b0;
        unique case (op)
            OP_MOVE:
            begin
                illegal = (dst_mode == M_PC_D16) || (dst_mode == M_PC_IDX)
                    || (dst_mode == M_IMM)
                    || ((src_m == M_D16) && (dst_idx || dst_abs))
                    || ((src_idx || src_abs || src_imm)
                        && ((dst_mode == M_D16) || dst_idx || dst_abs));
                reads = {7'h00, src_mem};
                writes = {7'h00, !dst_reg};
                if (src_reg)
                    cycles = `OPT_C_REG_MOVE + (dst_idx ? `OPT_C_IDX_ADD : 8'h00);
                else if (src_imm)
                    cycles = dst_reg ? `OPT_C_REG_MOVE
                        : (is_long ? `OPT_C_IMM_L : `OPT_C_IMM_BW);
                else
                    cycles = (is_long ? `OPT_C_MEM_L : `OPT_C_MEM_BW)
                        + (src_idx ? `OPT_C_IDX_ADD : 8'h00)
                        + (dst_idx ? `OPT_C_IDX_ADD : 8'h00);
            end
            OP_RMW:
            begin
                reads = 8'h01;
                writes = 8'h01;
            end
            OP_MULTI:
                writes = base_cycles;
        endcase
    end
endmodule

// file: dv/opt_mem_model.sv
// operand memory model on the core's local bus: zero-wait, logs each access
`timescale 1ns/1ps
module opt_mem_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire opt_pkg::opt_size_e mem_size,
    input wire logic [31:0] mem_addr
);
    import opt_pkg::*;
    // entries are {write, size, address}, in the order the core issued them
    logic [34:0] log_q[$];
    // no wait states and no ready: every strobe completes in its own cycle
    always @(posedge clk)
    begin
        if (nrst === 1'b1 && mem_req === 1'b1)
        begin
            log_q.push_back({mem_we, mem_size, mem_addr});
        end
    end
endmodule

// file: dv/tb_operand_pipeline_timing.sv
// self-checking testbench of the operand execution pipe
`timescale 1ns/1ps
module tb_operand_pipeline_timing;
    import opt_pkg::*;
    localparam logic [31:0] SA = 32'h0000_0100;
    localparam logic [31:0] DA = 32'h0000_0200;
    logic clk, nrst, ins_valid, ins_ready, store_stall, ins_done, ins_illegal, mem_req, mem_we;
    opt_op_e ins_op;
    opt_size_e ins_size, mem_size;
    opt_mode_e ins_src_mode, ins_dst_mode;
    logic [31:0] ins_src_addr, ins_dst_addr, mem_addr;
    logic [7:0] ins_base_cycles;
    int err_count, total_checks, waits, stalls;
    logic [34:0] exp_q[$];

    opt_pipe u_dut (.clk(clk), .nrst(nrst), .ins_valid(ins_valid), .ins_ready(ins_ready),
        .ins_op(ins_op), .ins_size(ins_size), .ins_src_mode(ins_src_mode),
        .ins_dst_mode(ins_dst_mode), .ins_src_addr(ins_src_addr), .ins_dst_addr(ins_dst_addr),
        .ins_base_cycles(ins_base_cycles), .store_stall(store_stall), .ins_done(ins_done),
        .ins_illegal(ins_illegal), .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size),
        .mem_addr(mem_addr));
    opt_mem_model u_mem (.clk(clk), .nrst(nrst), .mem_req(mem_req), .mem_we(mem_we),
        .mem_size(mem_size), .mem_addr(mem_addr));

    always #5 clk = ~clk;

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string what, input logic [34:0] exp, input logic [34:0] got);
        total_checks++;
        if (exp !== got)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // expected bus pieces of one operand, in issue order
    function automatic void split(input logic we, input opt_size_e sz, input logic [31:0] a);
        if (sz == SZ_WORD && a[0])
        begin
            exp_q.push_back({we, SZ_BYTE, a});
            exp_q.push_back({we, SZ_BYTE, a + 32'h0000_0001});
        end
        else if (sz == SZ_LONG && a[1:0] == 2'b10)
        begin
            exp_q.push_back({we, SZ_WORD, a});
            exp_q.push_back({we, SZ_WORD, a + 32'h0000_0002});
        end
        else if (sz == SZ_LONG && a[0])
        begin
            exp_q.push_back({we, SZ_BYTE, a});
            exp_q.push_back({we, SZ_WORD, a + 32'h0000_0001});
            exp_q.push_back({we, SZ_BYTE, a + 32'h0000_0003});
        end
        else
            exp_q.push_back({we, sz, a});
    endfunction

    // entered just after a rising edge; returns at the edge that takes the instruction
    task automatic offer(input opt_op_e op, input opt_size_e sz, input opt_mode_e sm,
        input opt_mode_e dm, input logic [31:0] sa, input logic [31:0] da, input logic [7:0] bc);
        waits = 0;
        stalls = 0;
        ins_valid <= 1'b1;
        ins_op <= op;
        ins_size <= sz;
        ins_src_mode <= sm;
        ins_dst_mode <= dm;
        ins_src_addr <= sa;
        ins_dst_addr <= da;
        ins_base_cycles <= bc;
        @(negedge clk);
        while (ins_ready !== 1'b1 && waits < 20)
        begin
            waits++;
            if (store_stall === 1'b1)
                stalls++;
            @(negedge clk);
        end
        check("ready after wait", 35'(1), 35'(ins_ready));
        @(posedge clk);
    endtask

    task automatic finish(input int et);
        int lows;
        ins_valid <= 1'b0;
        lows = 0;
        for (int i = 1; i <= et; i++)
        begin
            @(negedge clk);
            if (ins_ready === 1'b0)
                lows++;
        end
        @(negedge clk);
        check("done pulse", 35'(1), 35'(ins_done));
        check("ready low cycles", 35'(et - 1), 35'(lows));
        @(negedge clk);
        check("access count", 35'(exp_q.size()), 35'(u_mem.log_q.size()));
        if (exp_q.size() == u_mem.log_q.size())
            foreach (exp_q[i])
                check("access", exp_q[i], u_mem.log_q[i]);
        exp_q.delete();
        u_mem.log_q.delete();
        @(posedge clk);
    endtask

    task automatic go(input opt_op_e op, input opt_size_e sz, input opt_mode_e sm,
        input opt_mode_e dm, input logic [31:0] sa, input logic [31:0] da, input logic [7:0] bc,
        input int et, input logic rd, input logic wr);
        if (rd)
            split(1'b0, sz, sa);
        if (op == OP_MULTI)
            for (int i = 0; i < int'(bc); i++)
                exp_q.push_back({1'b1, SZ_LONG, da + 32'(4 * i)});
        else if (wr)
            split(1'b1, sz, da);
        offer(op, sz, sm, dm, sa, da, bc);
        finish(et);
    endtask

    task automatic sc_moves();
        go(OP_MOVE, SZ_WORD, M_DREG, M_DREG, SA, DA, 8'h00, 1, 1'b0, 1'b0);
        go(OP_MOVE, SZ_BYTE, M_IND, M_DREG, SA, DA, 8'h00, 3, 1'b1, 1'b0);
        go(OP_MOVE, SZ_WORD, M_POSTINC, M_IDX, SA, DA, 8'h00, 4, 1'b1, 1'b1);
        go(OP_MOVE, SZ_BYTE, M_IDX, M_PREDEC, SA, DA, 8'h00, 4, 1'b1, 1'b1);
        go(OP_MOVE, SZ_LONG, M_IND, M_IND, SA, DA, 8'h00, 2, 1'b1, 1'b1);
        go(OP_MOVE, SZ_LONG, M_IDX, M_DREG, SA, DA, 8'h00, 3, 1'b1, 1'b0);
        go(OP_MOVE, SZ_LONG, M_IND, M_IDX, SA, DA, 8'h00, 3, 1'b1, 1'b1);
        go(OP_MOVE, SZ_LONG, M_AREG, M_IDX, SA, DA, 8'h00, 2, 1'b0, 1'b1);
        go(OP_MOVE, SZ_LONG, M_IMM, M_IND, SA, DA, 8'h00, 2, 1'b0, 1'b1);
        go(OP_MOVE, SZ_WORD, M_IMM, M_POSTINC, SA, DA, 8'h00, 3, 1'b0, 1'b1);
        go(OP_MOVE, SZ_BYTE, M_IMM, M_DREG, SA, DA, 8'h00, 1, 1'b0, 1'b0);
    endtask

    task automatic sc_pcrel();
        go(OP_MOVE, SZ_LONG, M_PC_D16, M_D16, SA, DA, 8'h00, 2, 1'b1, 1'b1);
        go(OP_MOVE, SZ_WORD, M_PC_IDX, M_DREG, SA, DA, 8'h00, 4, 1'b1, 1'b0);
        go(OP_MOVE, SZ_LONG, M_PC_IDX, M_IND, SA, DA, 8'h00, 3, 1'b1, 1'b1);
    endtask

    task automatic sc_misalign();
        go(OP_MOVE, SZ_WORD, M_IND, M_DREG, 32'h0000_0101, DA, 8'h00, 5, 1'b1, 1'b0);
        go(OP_MOVE, SZ_LONG, M_IND, M_DREG, 32'h0000_0102, DA, 8'h00, 4, 1'b1, 1'b0);
        go(OP_MOVE, SZ_LONG, M_ABSL, M_DREG, 32'h0000_0103, DA, 8'h00, 5, 1'b1, 1'b0);
        go(OP_MOVE, SZ_WORD, M_DREG, M_IND, SA, 32'h0000_0203, 8'h00, 2, 1'b0, 1'b1);
        go(OP_MOVE, SZ_LONG, M_DREG, M_IND, SA, 32'h0000_0202, 8'h00, 2, 1'b0, 1'b1);
        go(OP_MOVE, SZ_LONG, M_DREG, M_IND, SA, 32'h0000_0201, 8'h00, 3, 1'b0, 1'b1);
    endtask

    task automatic sc_rmw();
        go(OP_RMW, SZ_LONG, M_IND, M_IND, SA, SA, 8'h03, 3, 1'b1, 1'b1);
        // read-modify-write touches one operand, so both addresses share the misalignment
        go(OP_RMW, SZ_WORD, M_IND, M_IND, 32'h0000_0101, 32'h0000_0101, 8'h04, 7, 1'b1,
            1'b1);
        go(OP_RMW, SZ_LONG, M_IND, M_IND, 32'h0000_0101, 32'h0000_0101, 8'h03, 8, 1'b1,
            1'b1);
    endtask

    // each case offers a store, then a second instruction at the very next edge
    task automatic sc_stall();
        split(1'b1, SZ_LONG, DA);
        offer(OP_MOVE, SZ_LONG, M_DREG, M_IND, SA, DA, 8'h00);
        go(OP_MOVE, SZ_LONG, M_DREG, M_POSTINC, SA, SA, 8'h00, 1, 1'b0, 1'b1);
        check("store stall cycles", 35'(2), 35'(stalls));
        check("store wait cycles", 35'(2), 35'(waits));
        split(1'b1, SZ_LONG, DA);
        offer(OP_MOVE, SZ_LONG, M_DREG, M_IND, SA, DA, 8'h00);
        go(OP_RMW, SZ_LONG, M_IND, M_IND, SA, SA, 8'h03, 3, 1'b1, 1'b1);
        check("rmw stall cycles", 35'(2), 35'(stalls));
        split(1'b1, SZ_LONG, DA);
        offer(OP_MOVE, SZ_LONG, M_DREG, M_IND, SA, DA, 8'h00);
        go(OP_MOVE, SZ_LONG, M_DREG, M_DREG, SA, DA, 8'h00, 1, 1'b0, 1'b0);
        check("non-store wait cycles", 35'(0), 35'(waits));
        split(1'b1, SZ_LONG, DA);
        offer(OP_MOVE, SZ_LONG, M_DREG, M_IND, SA, DA, 8'h00);
        go(OP_MULTI, SZ_LONG, M_DREG, M_IND, SA, 32'h0000_0300, 8'h02, 2, 1'b0, 1'b1);
        check("multi wait cycles", 35'(0), 35'(waits));
    endtask

    task automatic sc_illegal();
        offer(OP_MOVE, SZ_LONG, M_IDX, M_D16, SA, DA, 8'h00);
        ins_valid <= 1'b0;
        @(negedge clk);
        check("illegal pulse", 35'(1), 35'(ins_illegal));
        @(posedge clk);
        offer(OP_MOVE, SZ_WORD, M_DREG, M_IMM, SA, DA, 8'h00);
        ins_valid <= 1'b0;
        @(negedge clk);
        check("illegal pulse", 35'(1), 35'(ins_illegal));
        repeat (3) @(negedge clk);
        check("illegal accesses", 35'(0), 35'(u_mem.log_q.size()));
        check("illegal done", 35'(0), 35'(ins_done));
        @(posedge clk);
    endtask

    // about 200 cycles of tests; the limit leaves ample margin for stalls
    initial
    begin
        #(3000 * 10);
        err_count++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        print_verdict();
    end

    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        ins_valid = 1'b0;
        ins_op = OP_MOVE;
        ins_size = SZ_BYTE;
        ins_src_mode = M_DREG;
        ins_dst_mode = M_DREG;
        ins_src_addr = 32'h0000_0000;
        ins_dst_addr = 32'h0000_0000;
        ins_base_cycles = 8'h00;
        err_count = 0;
        total_checks = 0;
        repeat (16) @(posedge clk);
        check("ready in reset", 35'(1), 35'(ins_ready));
        check("mem_req in reset", 35'(0), 35'(mem_req));
        nrst <= 1'b1;
        @(posedge clk);
        sc_moves();
        sc_pcrel();
        sc_misalign();
        sc_rmw();
        sc_stall();
        sc_illegal();
        print_verdict();
    end
endmodule
